// [hw/eebac_pkg.sv]
// Purpose: shared constants for the byte access controller of the data nonvolatile array
// Assumes: i/o-space register port on the cpu clock, oscillator ticks as a synchronous pulse
// Notes: programming times are counted in oscillator ticks

package eebac_pkg;

    // array geometry
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;
    localparam int ARRAY_DEPTH = 512;
    localparam logic [8:0] ADDR_TOP = 9'h1FF;

    // register bus address space
    localparam int BUS_ADDR_W = 7;
    localparam logic [6:0] IO_SPACE_TOP = 7'h3F;
    localparam logic [6:0] BIT_IO_TOP = 7'h1F;
    localparam logic [6:0] DATA_SPACE_OFFSET = 7'h20;
    localparam logic [6:0] DATA_SPACE_TOP = 7'h5F;

    // register offsets in i/o space
    localparam logic [6:0] ADDR_NV_CONTROL = 7'h1C;
    localparam logic [6:0] ADDR_NV_DATA_BYTE = 7'h1D;
    localparam logic [6:0] ADDR_BYTE_ADDRESS_LOW = 7'h1E;
    localparam logic [6:0] ADDR_BYTE_ADDRESS_HIGH = 7'h1F;

    // nv_control field positions
    localparam int CTRL_READ_STROBE = 0;
    localparam int CTRL_PROGRAM_STROBE = 1;
    localparam int CTRL_MASTER_ARM = 2;
    localparam int CTRL_READY_IRQ_EN = 3;
    localparam int CTRL_MODE_LSB = 4;
    localparam int CTRL_MODE_MSB = 5;

    // reset values
    localparam logic [7:0] NV_DATA_BYTE_RESET = 8'h00;
    localparam logic [8:0] NV_BYTE_ADDRESS_RESET = 9'h000;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // program_mode_select encodings
    localparam logic [1:0] MODE_ATOMIC = 2'h0;
    localparam logic [1:0] MODE_ERASE = 2'h1;
    localparam logic [1:0] MODE_WRITE = 2'h2;
    localparam logic [1:0] MODE_RESERVED = 2'h3;

    // erased cell value
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // programming times in microseconds, and oscillator tick rate
    localparam int PROG_TIME_ATOMIC_US = 3400;
    localparam int PROG_TIME_SPLIT_US = 1800;
    localparam int OSC_TICK_KHZ = 1000;
    localparam int TICK_CNT_W = 16;

    // cpu cycle figures
    localparam int CLK_SYS_MHZ = 40;
    localparam logic [2:0] ARM_WINDOW_CYCLES = 3'h4;
    localparam logic [2:0] PROG_STALL_CYCLES = 3'h2;
    localparam logic [2:0] READ_STALL_CYCLES = 3'h4;

    typedef enum logic {
        EEBAC_IDLE,
        EEBAC_PROG
    } eebac_state_t;

endpackage

// [hw/eebac_array.sv]
// Purpose: byte array of the nonvolatile store with a registered read port
// Assumes: one program commit and one read at most per cycle
// Notes: write-only cells keep only bits that are one in both old and new data

`timescale 1ns/1ps
`default_nettype none

module eebac_array
    import eebac_pkg::*;
#(
    parameter int P_DEPTH = ARRAY_DEPTH
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_commit,
    input wire logic [1:0] i_commit_mode,
    input wire logic [ADDR_W-1:0] i_commit_addr,
    input wire logic [DATA_W-1:0] i_commit_data,
    input wire logic i_read,
    input wire logic [ADDR_W-1:0] i_read_addr,
    output logic [DATA_W-1:0] o_read_data
);

    logic [DATA_W-1:0] cells [P_DEPTH];

    always_ff @(posedge i_clk_sys) begin
        if (i_commit) begin
            case (i_commit_mode)
                MODE_ATOMIC: cells[i_commit_addr] <= i_commit_data;
                MODE_ERASE: cells[i_commit_addr] <= ERASED_BYTE;
                MODE_WRITE: cells[i_commit_addr] <= cells[i_commit_addr] & i_commit_data;
                default: cells[i_commit_addr] <= cells[i_commit_addr];
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_read_data <= READ_ZERO;
        end else if (i_read) begin
            o_read_data <= cells[i_read_addr];
        end
    end

endmodule

`default_nettype wire

// [hw/eebac_ctrl.sv]
// Purpose: cpu-side control of single byte reads and programming of the nonvolatile array
// Assumes: bus strobes and oscillator ticks synchronous to i_clk_sys
// Notes: programming engine survives i_reset_n, cleared only by i_por_n; mode field cleared by i_reset_n only while idle

`timescale 1ns/1ps
`default_nettype none

//Contract
// - nine-bit linear byte address over two registers
// - unused high address, control top bits read zero
// - programming stores data byte at address
// - read places fetched byte in data register
// - mode selects atomic, erase, write, reserved times
// - mode writes ignored while program strobe set
// - reset clears mode unless programming busy
// - ready interrupt needs enable and global enable
// - ready interrupt is a level while idle
// - program starts only within four-cycle arm window
// - strobe without arm does nothing
// - arm bit self-clears four cycles after set
// - program strobe stays set for programming time
// - program start stalls cpu two cycles
// - read strobe reads byte within one instruction
// - read stalls cpu four cycles
// - busy refuses reads and address writes
// - reset does not abort running programming
// - io addresses, data space at plus 0x20
// - single-bit set and clear touch one bit
// - write-only over unerased cell gives undefined data
// - no other operation starts while busy
module eebac_ctrl
    import eebac_pkg::*;
#(
    parameter int P_OSC_TICK_KHZ = OSC_TICK_KHZ
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_por_n,
    input wire logic i_bus_wr,
    input wire logic i_bus_rd,
    input wire logic i_bit_set,
    input wire logic i_bit_clr,
    input wire logic [2:0] i_bit_num,
    input wire logic i_data_space,
    input wire logic [BUS_ADDR_W-1:0] i_bus_addr,
    input wire logic [DATA_W-1:0] i_bus_wdata,
    input wire logic i_global_irq_en,
    input wire logic i_osc_tick,
    output logic [DATA_W-1:0] o_bus_rdata,
    output logic o_cpu_stall,
    output logic o_ready_irq,
    output logic o_busy
);

    // tick counts for each programming time
    localparam int TICKS_ATOMIC_I = (PROG_TIME_ATOMIC_US * P_OSC_TICK_KHZ) / 1000;
    localparam int TICKS_SPLIT_I = (PROG_TIME_SPLIT_US * P_OSC_TICK_KHZ) / 1000;
    localparam logic [TICK_CNT_W-1:0] TICKS_ATOMIC =
        TICK_CNT_W'((TICKS_ATOMIC_I < 1) ? 1 : TICKS_ATOMIC_I);
    localparam logic [TICK_CNT_W-1:0] TICKS_SPLIT =
        TICK_CNT_W'((TICKS_SPLIT_I < 1) ? 1 : TICKS_SPLIT_I);
    localparam logic [TICK_CNT_W-1:0] TICK_ONE = TICK_CNT_W'(1);

    // software-visible state
    logic [ADDR_W-1:0] nv_byte_address;
    logic [DATA_W-1:0] nv_data_byte;
    logic [1:0] program_mode_select;
    logic ready_irq_enable;
    logic master_program_arm;
    logic [2:0] arm_cnt;
    logic read_pending;
    logic [2:0] stall_cnt;

    // programming engine, kept across i_reset_n
    eebac_state_t state;
    logic [TICK_CNT_W-1:0] tick_cnt;
    logic [TICK_CNT_W-1:0] tick_target;
    logic [1:0] prog_mode;
    logic [ADDR_W-1:0] prog_addr;
    logic [DATA_W-1:0] prog_data;

    // array read data
    logic [DATA_W-1:0] array_rdata;

    // address decode for both address spaces
    wire [BUS_ADDR_W-1:0] io_addr;
    wire space_ok;
    wire bit_op;
    wire any_wr;
    wire [DATA_W-1:0] wmask;
    wire [DATA_W-1:0] wval;

    assign io_addr = i_data_space ? (i_bus_addr - DATA_SPACE_OFFSET) : i_bus_addr;
    assign space_ok = i_data_space ?
        ((i_bus_addr >= DATA_SPACE_OFFSET) && (i_bus_addr <= DATA_SPACE_TOP)) :
        (i_bus_addr <= IO_SPACE_TOP);

    // bit instructions exist in i/o space up to and including the bit-access top only
    assign bit_op = (i_bit_set | i_bit_clr) & ~i_data_space & (i_bus_addr <= BIT_IO_TOP);
    assign any_wr = (i_bus_wr | bit_op) & space_ok;
    assign wmask = bit_op ? (8'h01 << i_bit_num) : 8'hFF;
    assign wval = bit_op ? {DATA_W{i_bit_set}} : i_bus_wdata;

    wire sel_ctrl;
    wire sel_data;
    wire sel_addr_lo;
    wire sel_addr_hi;

    assign sel_ctrl = any_wr & (io_addr == ADDR_NV_CONTROL);
    assign sel_data = any_wr & (io_addr == ADDR_NV_DATA_BYTE);
    assign sel_addr_lo = any_wr & (io_addr == ADDR_BYTE_ADDRESS_LOW);
    assign sel_addr_hi = any_wr & (io_addr == ADDR_BYTE_ADDRESS_HIGH);

    // register readback
    wire busy;
    wire [DATA_W-1:0] rd_ctrl;
    wire [DATA_W-1:0] rd_data;
    wire [DATA_W-1:0] rd_addr_lo;
    wire [DATA_W-1:0] rd_addr_hi;
    wire [DATA_W-1:0] rd_val;

    assign busy = (state == EEBAC_PROG);
    assign rd_ctrl = {2'b00, program_mode_select, ready_irq_enable,
                      master_program_arm, busy, read_pending};
    assign rd_data = nv_data_byte;
    assign rd_addr_lo = nv_byte_address[7:0];
    assign rd_addr_hi = {7'h00, nv_byte_address[8]};
    assign rd_val = (io_addr == ADDR_NV_CONTROL) ? rd_ctrl :
                    (io_addr == ADDR_NV_DATA_BYTE) ? rd_data :
                    (io_addr == ADDR_BYTE_ADDRESS_LOW) ? rd_addr_lo :
                    (io_addr == ADDR_BYTE_ADDRESS_HIGH) ? rd_addr_hi : READ_ZERO;

    // merged write values, untouched bits keep their current value
    wire [DATA_W-1:0] next_ctrl_w;
    wire [DATA_W-1:0] next_data_w;
    wire [DATA_W-1:0] next_lo_w;
    wire [DATA_W-1:0] next_hi_w;

    assign next_ctrl_w = (rd_ctrl & ~wmask) | (wval & wmask);
    assign next_data_w = (rd_data & ~wmask) | (wval & wmask);
    assign next_lo_w = (rd_addr_lo & ~wmask) | (wval & wmask);
    assign next_hi_w = (rd_addr_hi & ~wmask) | (wval & wmask);

    // operation requests
    wire strobe_wr;
    wire start_req;
    wire read_req;
    wire arm_wr;

    assign strobe_wr = sel_ctrl & wmask[CTRL_PROGRAM_STROBE] & next_ctrl_w[CTRL_PROGRAM_STROBE];
    assign start_req = strobe_wr & master_program_arm & ~busy;
    assign read_req = sel_ctrl & wmask[CTRL_READ_STROBE] & next_ctrl_w[CTRL_READ_STROBE]
                      & ~busy;
    assign arm_wr = sel_ctrl & wmask[CTRL_MASTER_ARM];

    // programming engine next state
    wire tick_done;
    wire prog_done;
    wire commit;
    wire [TICK_CNT_W-1:0] start_target;
    eebac_state_t next_state;
    logic [TICK_CNT_W-1:0] next_tick_cnt;

    assign start_target = (program_mode_select == MODE_ATOMIC) ? TICKS_ATOMIC : TICKS_SPLIT;
    assign tick_done = i_osc_tick & (tick_cnt == (tick_target - TICK_ONE));
    assign prog_done = busy & ((prog_mode == MODE_RESERVED) | tick_done);
    assign commit = prog_done & (prog_mode != MODE_RESERVED);

    always_comb begin
        next_state = state;
        next_tick_cnt = tick_cnt;
        case (state)
            EEBAC_IDLE: begin
                if (start_req) begin
                    next_state = EEBAC_PROG;
                    next_tick_cnt = '0;
                end
            end
            EEBAC_PROG: begin
                if (prog_done) begin
                    next_state = EEBAC_IDLE;
                end else if (i_osc_tick) begin
                    next_tick_cnt = tick_cnt + TICK_ONE;
                end
            end
            default: begin
                next_state = EEBAC_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_por_n) begin
        if (!i_por_n) begin
            state <= EEBAC_IDLE;
            tick_cnt <= '0;
        end else begin
            state <= next_state;
            tick_cnt <= next_tick_cnt;
        end
    end

    // operation snapshot, taken at start and held through a later reset
    always_ff @(posedge i_clk_sys or negedge i_por_n) begin
        if (!i_por_n) begin
            tick_target <= TICKS_ATOMIC;
            prog_mode <= MODE_RESET;
            prog_addr <= NV_BYTE_ADDRESS_RESET;
            prog_data <= NV_DATA_BYTE_RESET;
        end else if (start_req) begin
            tick_target <= start_target;
            prog_mode <= program_mode_select;
            prog_addr <= nv_byte_address;
            prog_data <= nv_data_byte;
        end
    end

    // mode field: cleared by reset only while idle, frozen while strobe set
    wire mode_wr;
    wire [1:0] next_mode;

    assign mode_wr = sel_ctrl & (|wmask[CTRL_MODE_MSB:CTRL_MODE_LSB]) & ~busy;
    assign next_mode = (!i_reset_n && !busy) ? MODE_RESET :
                       mode_wr ? next_ctrl_w[CTRL_MODE_MSB:CTRL_MODE_LSB] : program_mode_select;

    always_ff @(posedge i_clk_sys or negedge i_por_n) begin
        if (!i_por_n) begin
            program_mode_select <= MODE_RESET;
        end else begin
            program_mode_select <= next_mode;
        end
    end

    // master arm window
    logic [2:0] next_arm_cnt;

    always_comb begin
        next_arm_cnt = (arm_cnt != 3'h0) ? (arm_cnt - 3'h1) : 3'h0;
        if (arm_wr) begin
            next_arm_cnt = next_ctrl_w[CTRL_MASTER_ARM] ? ARM_WINDOW_CYCLES : 3'h0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            arm_cnt <= 3'h0;
            master_program_arm <= 1'b0;
        end else begin
            arm_cnt <= next_arm_cnt;
            master_program_arm <= (next_arm_cnt != 3'h0);
        end
    end

    // interrupt enable
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ready_irq_enable <= 1'b0;
        end else if (sel_ctrl && wmask[CTRL_READY_IRQ_EN]) begin
            ready_irq_enable <= next_ctrl_w[CTRL_READY_IRQ_EN];
        end
    end

    // address registers, locked while programming
    wire [ADDR_W-1:0] next_address;

    assign next_address = (sel_addr_hi && !busy) ? {next_hi_w[0], nv_byte_address[7:0]} :
                          (sel_addr_lo && !busy) ? {nv_byte_address[8], next_lo_w} :
                          nv_byte_address;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            nv_byte_address <= NV_BYTE_ADDRESS_RESET;
        end else begin
            nv_byte_address <= next_address;
        end
    end

    // data register: read result takes priority over a software write
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            nv_data_byte <= NV_DATA_BYTE_RESET;
        end else if (read_pending) begin
            nv_data_byte <= array_rdata;
        end else if (sel_data) begin
            nv_data_byte <= next_data_w;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            read_pending <= 1'b0;
        end else begin
            read_pending <= read_req;
        end
    end

    // cpu stall
    logic [2:0] next_stall_cnt;

    always_comb begin
        next_stall_cnt = (stall_cnt != 3'h0) ? (stall_cnt - 3'h1) : 3'h0;
        if (start_req) begin
            next_stall_cnt = PROG_STALL_CYCLES;
        end else if (read_req) begin
            next_stall_cnt = READ_STALL_CYCLES;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            stall_cnt <= 3'h0;
            o_cpu_stall <= 1'b0;
        end else begin
            stall_cnt <= next_stall_cnt;
            o_cpu_stall <= (next_stall_cnt != 3'h0);
        end
    end

    // registered outputs
    wire read_hit;

    assign read_hit = i_bus_rd & space_ok;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_bus_rdata <= READ_ZERO;
            o_ready_irq <= 1'b0;
        end else begin
            o_bus_rdata <= read_hit ? rd_val : READ_ZERO;
            o_ready_irq <= ready_irq_enable & i_global_irq_en & (next_state == EEBAC_IDLE);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_por_n) begin
        if (!i_por_n) begin
            o_busy <= 1'b0;
        end else begin
            o_busy <= (next_state == EEBAC_PROG);
        end
    end

    eebac_array #(
        .P_DEPTH(ARRAY_DEPTH)
    ) u_array (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_commit(commit),
        .i_commit_mode(prog_mode),
        .i_commit_addr(prog_addr),
        .i_commit_data(prog_data),
        .i_read(read_req),
        .i_read_addr(nv_byte_address),
        .o_read_data(array_rdata)
    );

endmodule

`default_nettype wire

// [test/eebac_ctrl_sva.sv]
// Purpose: port checker for eebac_ctrl
// Assumes: one clock, both resets active low
// Notes: age of the arm bit is counted in helper logic
`timescale 1ns/1ps
`default_nettype none
module eebac_ctrl_sva
    import eebac_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_por_n,
    input wire logic i_bus_wr,
    input wire logic i_bus_rd,
    input wire logic i_bit_set,
    input wire logic i_bit_clr,
    input wire logic [2:0] i_bit_num,
    input wire logic i_data_space,
    input wire logic [BUS_ADDR_W-1:0] i_bus_addr,
    input wire logic [DATA_W-1:0] i_bus_wdata,
    input wire logic i_global_irq_en,
    input wire logic [DATA_W-1:0] o_bus_rdata,
    input wire logic o_cpu_stall,
    input wire logic o_ready_irq,
    input wire logic o_busy
);
    wire logic ctl_io = !i_data_space && i_bus_addr == ADDR_NV_CONTROL;
    wire logic ctl_ds = i_data_space && i_bus_addr == ADDR_NV_CONTROL + DATA_SPACE_OFFSET;
    wire logic ctl_wr = i_bus_wr && (ctl_io || ctl_ds);
    wire logic bit_arm = ctl_io && i_bit_num == 3'(CTRL_MASTER_ARM);
    wire logic arm_set = ctl_wr && i_bus_wdata[CTRL_MASTER_ARM] || bit_arm && i_bit_set;
    wire logic arm_clr = ctl_wr && !i_bus_wdata[CTRL_MASTER_ARM] || bit_arm && i_bit_clr;
    wire logic prog_req = ctl_wr && i_bus_wdata[CTRL_PROGRAM_STROBE]
        || ctl_io && i_bit_num == 3'(CTRL_PROGRAM_STROBE) && i_bit_set;
    wire logic read_req = ctl_wr && i_bus_wdata[CTRL_READ_STROBE]
        || ctl_io && i_bit_num == 3'(CTRL_READ_STROBE) && i_bit_set;
    wire logic quiet = !i_bus_wr && !i_bit_set && !i_bit_clr;
    logic [2:0] arm_age;
    wire logic armed = arm_age != 3'h0 && arm_age <= ARM_WINDOW_CYCLES;
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            arm_age <= 3'h0;
        end else if (arm_set) begin
            arm_age <= 3'h1;
        end else if (arm_clr) begin
            arm_age <= 3'h0;
        end else if (arm_age != 3'h0 && arm_age != 3'h7) begin
            arm_age <= arm_age + 3'h1;
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n || !i_por_n);
    prog_stall_a: assert property ($rose(o_busy) |-> o_cpu_stall [*2] ##1 !o_cpu_stall)
        else $error("program stall length wrong");
    read_stall_a: assert property (read_req && !o_busy |=> o_cpu_stall [*4] ##1 !o_cpu_stall)
        else $error("read stall length wrong");
    busy_read_a: assert property (read_req && o_busy && !o_cpu_stall |=> !o_cpu_stall)
        else $error("read taken while busy");
    no_arm_a: assert property (prog_req && !o_busy && !armed |=> !o_busy)
        else $error("program started without arm");
    arm_start_a: assert property (prog_req && !o_busy && armed |=> o_busy)
        else $error("armed program did not start");
    irq_busy_a: assert property (o_busy |-> !o_ready_irq)
        else $error("ready request while busy");
    irq_global_a: assert property (!i_global_irq_en |=> !o_ready_irq)
        else $error("ready request without global enable");
    irq_level_a: assert property (o_ready_irq && i_global_irq_en && quiet |=> o_ready_irq)
        else $error("ready request not held");
    rdata_idle_a: assert property (!i_bus_rd |=> o_bus_rdata == READ_ZERO)
        else $error("read data not zero after idle cycle");
    unmapped_a: assert property (i_bus_rd && !i_data_space && i_bus_addr < ADDR_NV_CONTROL
        |=> o_bus_rdata == READ_ZERO) else $error("unmapped read not zero");
endmodule
bind eebac_ctrl eebac_ctrl_sva u_sva (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_por_n(i_por_n),
    .i_bus_wr(i_bus_wr), .i_bus_rd(i_bus_rd), .i_bit_set(i_bit_set), .i_bit_clr(i_bit_clr),
    .i_bit_num(i_bit_num), .i_data_space(i_data_space), .i_bus_addr(i_bus_addr), .i_bus_wdata(i_bus_wdata),
    .i_global_irq_en(i_global_irq_en), .o_bus_rdata(o_bus_rdata), .o_cpu_stall(o_cpu_stall),
    .o_ready_irq(o_ready_irq), .o_busy(o_busy));
`default_nettype wire

// [test/tb_eeprom_byte_access_ctrl.sv]
// Purpose: register level bench for eebac_ctrl
// Assumes: oscillator tick every fourth cycle, one tick per microsecond per thousand
// Notes: each bus op takes two cycles
`timescale 1ns/1ps
`default_nettype none
module tb_eeprom_byte_access_ctrl
    import eebac_pkg::*;
;
    logic clk, rst_n, por_n, wr, rd, bs, bc, ds, gie;
    logic tick = 1'b0;
    logic [2:0] bn;
    logic [6:0] addr;
    logic [7:0] wdata, rdata;
    logic stall, irq, busy;
    logic [1:0] tcnt = 2'h0;
    int failures = 0;
    int n_compared = 0;
    int cyc = 0;
    int t0;
    eebac_ctrl #(.P_OSC_TICK_KHZ(1)) dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_por_n(por_n), .i_bus_wr(wr),
        .i_bus_rd(rd), .i_bit_set(bs), .i_bit_clr(bc), .i_bit_num(bn), .i_data_space(ds), .i_bus_addr(addr),
        .i_bus_wdata(wdata), .i_global_irq_en(gie), .i_osc_tick(tick), .o_bus_rdata(rdata),
        .o_cpu_stall(stall), .o_ready_irq(irq), .o_busy(busy));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        #1;
        tcnt <= tcnt + 2'h1;
        tick <= tcnt == 2'h3;
    end
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic op(input logic w, r, s, c, input logic [2:0] n, input logic d, input logic [6:0] a,
                      input logic [7:0] v);
        @(posedge clk);
        #1;
        {wr, rd, bs, bc, bn, ds, addr, wdata} = {w, r, s, c, n, d, a, v};
        @(posedge clk);
        #1;
        {wr, rd, bs, bc} = 4'h0;
    endtask
    task automatic wr_reg(input logic [6:0] a, input logic [7:0] v);
        op(1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 1'b0, a, v);
    endtask
    task automatic rd_reg(input logic [6:0] a, input logic [7:0] exp, input string what);
        op(1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 1'b0, a, 8'h00);
        chk(what, rdata, exp);
    endtask
    task automatic sbit(input logic [2:0] n);
        op(1'b0, 1'b0, 1'b1, 1'b0, n, 1'b0, ADDR_NV_CONTROL, 8'h00);
    endtask
    task automatic start(input logic [1:0] m, input logic [7:0] v, input int gap);
        wr_reg(ADDR_NV_CONTROL, {2'h0, m, 4'h8});
        wr_reg(ADDR_NV_DATA_BYTE, v);
        sbit(3'h2);
        repeat (gap) @(posedge clk);
        sbit(3'h1);
        t0 = cyc;
    endtask
    task automatic finish(input int lo, input int hi);
        while (busy === 1'b1 && cyc - t0 < 100) begin
            @(posedge clk);
            #1;
        end
        chk("busy cycles", 8'(cyc - t0 >= lo && cyc - t0 <= hi), 8'h01);
    endtask
    task automatic fetch(input logic [8:0] a, input logic [7:0] exp);
        wr_reg(ADDR_BYTE_ADDRESS_HIGH, {7'h00, a[8]});
        wr_reg(ADDR_BYTE_ADDRESS_LOW, a[7:0]);
        sbit(3'h0);
        for (int i = 0; i < 5; i++) begin
            chk("read stall", 8'(stall), 8'(i < 4));
            @(posedge clk);
            #1;
        end
        rd_reg(ADDR_NV_DATA_BYTE, exp, "data byte");
    endtask
    task automatic stop_test();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        {rst_n, por_n, wr, rd, bs, bc, ds, gie, bn, addr, wdata} = '0;
        gie = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        {rst_n, por_n} = 2'h3;
        rd_reg(ADDR_NV_CONTROL, 8'h00, "control reset");
        rd_reg(ADDR_NV_DATA_BYTE, NV_DATA_BYTE_RESET, "data reset");
        wr_reg(ADDR_BYTE_ADDRESS_HIGH, 8'hFF);
        rd_reg(ADDR_BYTE_ADDRESS_HIGH, 8'h01, "address high");
        wr_reg(ADDR_NV_CONTROL, 8'hC8);
        rd_reg(ADDR_NV_CONTROL, 8'h08, "control top bits");
        chk("ready irq", 8'(irq), 8'h01);
        gie = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk("ready irq masked", 8'(irq), 8'h00);
        gie = 1'b1;
        rd_reg(7'h10, 8'h00, "unmapped");
        op(1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 1'b1, ADDR_NV_DATA_BYTE + DATA_SPACE_OFFSET, 8'hA5);
        op(1'b0, 1'b0, 1'b1, 1'b0, 3'h1, 1'b1, ADDR_NV_DATA_BYTE + DATA_SPACE_OFFSET, 8'h00);
        rd_reg(ADDR_NV_DATA_BYTE, 8'hA5, "data space write");
        op(1'b0, 1'b0, 1'b1, 1'b0, 3'h1, 1'b0, ADDR_NV_DATA_BYTE, 8'h00);
        op(1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 1'b0, ADDR_NV_DATA_BYTE, 8'h00);
        rd_reg(ADDR_NV_DATA_BYTE, 8'hA6, "bit set clear");
        wr_reg(ADDR_BYTE_ADDRESS_LOW, 8'hFF);
        start(MODE_ATOMIC, 8'h5A, 0);
        wr_reg(ADDR_BYTE_ADDRESS_LOW, 8'h00);
        sbit(3'h0);
        chk("read refused", 8'(stall), 8'h00);
        wr_reg(ADDR_NV_CONTROL, 8'h38);
        rd_reg(ADDR_NV_CONTROL, 8'h0A, "control busy");
        chk("ready irq busy", 8'(irq), 8'h00);
        finish(9, 12);
        rd_reg(ADDR_BYTE_ADDRESS_LOW, 8'hFF, "address locked");
        fetch(9'h1FF, 8'h5A);
        start(MODE_RESERVED, 8'h33, 0);
        finish(1, 1);
        fetch(9'h1FF, 8'h5A);
        start(MODE_ERASE, 8'h33, 2);
        finish(1, 4);
        fetch(9'h1FF, ERASED_BYTE);
        start(MODE_WRITE, 8'h0F, 0);
        finish(1, 4);
        fetch(9'h1FF, 8'h0F);
        start(MODE_ATOMIC, 8'h77, 3);
        chk("late strobe", 8'(busy), 8'h00);
        sbit(3'h1);
        chk("strobe unarmed", 8'(busy), 8'h00);
        start(MODE_ATOMIC, 8'hC3, 0);
        rst_n = 1'b0;
        @(posedge clk);
        #1;
        rst_n = 1'b1;
        chk("busy over reset", 8'(busy), 8'h01);
        finish(9, 12);
        fetch(9'h1FF, 8'hC3);
        wr_reg(ADDR_NV_CONTROL, 8'h20);
        rst_n = 1'b0;
        @(posedge clk);
        #1;
        rst_n = 1'b1;
        rd_reg(ADDR_NV_CONTROL, 8'h00, "mode after reset");
        stop_test();
    end
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        $display("watchdog expired");
        stop_test();
    end
endmodule
`default_nettype wire
